// [hdl/bras_pkg.sv]
package bras_pkg;
    // ==========================================
    // shapes
    typedef enum {
        SHAPE_256_BY_16,
        SHAPE_512_BY_8,
        SHAPE_1024_BY_4,
        SHAPE_2048_BY_2
    } bras_shape_e;

    // ==========================================
    // geometry
    localparam int unsigned TOTAL_BITS = 4096;
    localparam int unsigned W256_AW = 8;
    localparam int unsigned W256_DW = 16;
    localparam int unsigned W512_AW = 9;
    localparam int unsigned W512_DW = 8;
    localparam int unsigned W1024_AW = 10;
    localparam int unsigned W1024_DW = 4;
    localparam int unsigned W2048_AW = 11;
    localparam int unsigned W2048_DW = 2;
    localparam logic [15:0] MASK_NONE = 16'h0000;

    // ==========================================
    // edge variants
    localparam logic INVERTED_FETCH_EDGE_BASE = 1'b0;
    localparam logic INVERTED_STORE_EDGE_BASE = 1'b0;

    // ==========================================
    // port groups
    typedef struct packed {
        logic en;
        logic clk_en;
        logic [10:0] location;
        logic [15:0] data;
        logic [15:0] mask;
    } bras_store_s;

    typedef struct packed {
        logic en;
        logic clk_en;
        logic [10:0] location;
    } bras_fetch_s;
endpackage

// [hdl/bras_edge_ff.sv]
module bras_edge_ff #(
    parameter bit INVERT = 1'b0,
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // ==========================================
    // register on selected edge
    logic [W-1:0] pos_q;
    logic [W-1:0] neg_q;
    generate
        if (INVERT) begin : g_neg
            always_ff @(negedge clk or posedge rst) begin
                if (rst) begin
                    neg_q <= '0;
                end else if (load) begin
                    neg_q <= d;
                end
            end
            assign pos_q = '0;
            assign q = neg_q;
        end else begin : g_pos
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pos_q <= '0;
                end else if (load) begin
                    pos_q <= d;
                end
            end
            assign neg_q = '0;
            assign q = pos_q;
        end
    endgenerate
endmodule

// [hdl/bras_ram.sv]
// Function
// - 256x16 shape: 8-bit addresses, 16-bit data
// - 256x16 shape has 16-bit write mask
// - 512x8 shape: 9-bit addresses, no mask
// - 1024x4 shape: 10-bit addresses, no mask
// - 2048x2 shape: 11-bit addresses, no mask
// - base variant: both ports rising edge
// - inverted fetch edge: reads on falling
// - inverted store edge: writes on falling
// - both inverted: both ports on falling
// - separate write and read ports, concurrent
module bras_ram #(
    parameter bras_pkg::bras_shape_e SHAPE = bras_pkg::SHAPE_256_BY_16,
    parameter bit INVERTED_FETCH_EDGE = bras_pkg::INVERTED_FETCH_EDGE_BASE,
    parameter bit INVERTED_STORE_EDGE = bras_pkg::INVERTED_STORE_EDGE_BASE,
    parameter int unsigned AW =
        (SHAPE == bras_pkg::SHAPE_256_BY_16) ? bras_pkg::W256_AW :
        (SHAPE == bras_pkg::SHAPE_512_BY_8) ? bras_pkg::W512_AW :
        (SHAPE == bras_pkg::SHAPE_1024_BY_4) ? bras_pkg::W1024_AW :
        bras_pkg::W2048_AW,
    parameter int unsigned DW =
        (SHAPE == bras_pkg::SHAPE_256_BY_16) ? bras_pkg::W256_DW :
        (SHAPE == bras_pkg::SHAPE_512_BY_8) ? bras_pkg::W512_DW :
        (SHAPE == bras_pkg::SHAPE_1024_BY_4) ? bras_pkg::W1024_DW :
        bras_pkg::W2048_DW
) (
    input wire logic core_clk,
    input wire logic fetch_clk,
    input wire logic rst,
    input wire logic store_en,
    input wire logic store_clk_en,
    input wire logic [AW-1:0] store_location,
    input wire logic [DW-1:0] store_data,
    input wire logic [DW-1:0] store_mask,
    input wire logic fetch_en,
    input wire logic fetch_clk_en,
    input wire logic [AW-1:0] fetch_location,
    output logic [DW-1:0] fetch_data
);
    // ==========================================
    // storage
    localparam int unsigned DEPTH = bras_pkg::TOTAL_BITS / DW;
    localparam bit HAS_MASK = (SHAPE == bras_pkg::SHAPE_256_BY_16);
    logic [DW-1:0] mem [DEPTH];

    // ==========================================
    // store port decode
    wire store_go = store_en && store_clk_en;
    wire [DW-1:0] eff_mask = HAS_MASK ? store_mask : '0;
    wire [DW-1:0] old_word = mem[store_location];
    wire [DW-1:0] merged;

    // ==========================================
    // per-bit merge of new data and kept bits
    generate
        for (genvar i = 0; i < DW; i++) begin : g_merge
            assign merged[i] =
                eff_mask[i] ? old_word[i] : store_data[i];
        end
    endgenerate

    generate
        if (INVERTED_STORE_EDGE) begin : g_store_neg
            always_ff @(negedge core_clk) begin
                if (store_go) begin
                    mem[store_location] <= merged;
                end
            end
        end else begin : g_store_pos
            always_ff @(posedge core_clk) begin
                if (store_go) begin
                    mem[store_location] <= merged;
                end
            end
        end
    endgenerate

    // ==========================================
    // fetch port, independent of store port
    wire fetch_go = fetch_en && fetch_clk_en;
    wire [DW-1:0] fetch_word = mem[fetch_location];

    bras_edge_ff #(
        .INVERT(INVERTED_FETCH_EDGE),
        .W(DW)
    ) u_fetch (
        .clk(fetch_clk),
        .rst(rst),
        .load(fetch_go),
        .d(fetch_word),
        .q(fetch_data)
    );

    // ==========================================
    // checks on store side, either edge variant
    generate
        if (!INVERTED_STORE_EDGE) begin : g_store_chk_pos
            sequence s_store_req;
                store_go;
            endsequence

            property p_store_write;
                @(posedge core_clk)
                s_store_req |=>
                    mem[$past(store_location)] == $past(merged);
            endproperty
            a_store_write: assert property (p_store_write)
                else $error("store word not written");

            property p_store_mask;
                @(posedge core_clk)
                s_store_req |=>
                    (mem[$past(store_location)] & $past(eff_mask)) ==
                    ($past(old_word) & $past(eff_mask));
            endproperty
            a_store_mask: assert property (p_store_mask)
                else $error("masked bits changed on store");
        end else begin : g_store_chk_neg
            sequence s_store_req;
                store_go;
            endsequence

            property p_store_write;
                @(negedge core_clk)
                s_store_req |=>
                    mem[$past(store_location)] == $past(merged);
            endproperty
            a_store_write: assert property (p_store_write)
                else $error("store word not written");

            property p_store_mask;
                @(negedge core_clk)
                s_store_req |=>
                    (mem[$past(store_location)] & $past(eff_mask)) ==
                    ($past(old_word) & $past(eff_mask));
            endproperty
            a_store_mask: assert property (p_store_mask)
                else $error("masked bits changed on store");
        end
    endgenerate

    // ==========================================
    // checks on fetch side, rising-edge variant
    generate
        if (!INVERTED_FETCH_EDGE) begin : g_chk
            property p_fetch_hold;
                @(posedge fetch_clk) disable iff (rst)
                !fetch_go |=> $stable(fetch_data);
            endproperty
            a_fetch_hold: assert property (p_fetch_hold)
                else $error("fetch data moved without enable");

            property p_fetch_load;
                @(posedge fetch_clk) disable iff (rst)
                fetch_go |=> fetch_data == $past(fetch_word);
            endproperty
            a_fetch_load: assert property (p_fetch_load)
                else $error("fetch data not loaded");

            sequence s_fetch_released;
                $fell(rst);
            endsequence

            property p_fetch_clear;
                @(posedge fetch_clk)
                rst |-> fetch_data == '0;
            endproperty
            a_fetch_clear: assert property (p_fetch_clear)
                else $error("fetch data not cleared in reset");

            property p_fetch_release;
                @(posedge fetch_clk)
                s_fetch_released |-> fetch_data == '0;
            endproperty
            a_fetch_release: assert property (p_fetch_release)
                else $error("fetch data moved before first read");
        end
    endgenerate
endmodule

// [verification/bras_user.sv]
// ==========================================
// fabric-side user logic driving both ports
module bras_user (
    input wire logic clk,
    output bras_pkg::bras_store_s st,
    output bras_pkg::bras_fetch_s ft
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        st = '0;
        ft = '0;
    end

    // ==========================================
    // write: both enables with the word for one edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input logic [15:0] m);
        @(posedge clk);
        st <= {2'b11, 3'h0, a, d, m};
        @(posedge clk);
        st <= {2'b00, 3'h7, ~a, ~d, ~m};
    endtask

    // ==========================================
    // read: both enables with the location for one edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        ft <= {2'b11, 3'h0, a};
        @(posedge clk);
        ft <= {2'b00, 3'h7, ~a};
    endtask
endmodule

// [verification/block_ram_aspect_config_test.sv]
module block_ram_aspect_config_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk;
    logic rst;
    logic [15:0] fetch_data;
    logic [1:0] fetch_data_nar;
    bras_pkg::bras_store_s st;
    bras_pkg::bras_fetch_s ft;
    int error_cnt = 0;
    int total_checks = 0;

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    bras_user i_usr (.clk(core_clk), .st(st), .ft(ft));

    bras_ram #(.SHAPE(bras_pkg::SHAPE_256_BY_16)) i_dut (
        .core_clk(core_clk), .fetch_clk(core_clk), .rst(rst),
        .store_en(st.en), .store_clk_en(st.clk_en),
        .store_location(st.location[7:0]), .store_data(st.data),
        .store_mask(st.mask), .fetch_en(ft.en), .fetch_clk_en(ft.clk_en),
        .fetch_location(ft.location[7:0]), .fetch_data(fetch_data)
    );

    bras_ram #(
        .SHAPE(bras_pkg::SHAPE_2048_BY_2),
        .INVERTED_FETCH_EDGE(1'b1),
        .INVERTED_STORE_EDGE(1'b1)
    ) i_dut_nar (
        .core_clk(core_clk), .fetch_clk(core_clk), .rst(rst),
        .store_en(st.en), .store_clk_en(st.clk_en),
        .store_location(st.location), .store_data(st.data[1:0]),
        .store_mask(st.mask[1:0]), .fetch_en(ft.en),
        .fetch_clk_en(ft.clk_en), .fetch_location(ft.location),
        .fetch_data(fetch_data_nar)
    );

    // ==========================================
    // compare and verdict
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %0t: read %h expected %h", $time, g, e);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        i_usr.rd(a);
        #1;
        chk(fetch_data, e);
    endtask

    task automatic rdchk_nar(input logic [7:0] a, input logic [1:0] e);
        i_usr.rd(a);
        #1;
        chk({14'h0000, fetch_data_nar}, {14'h0000, e});
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_plain();
        i_usr.wr(8'h00, 16'hA5C3, 16'h0000);
        i_usr.wr(8'hFF, 16'h5A3C, 16'h0000);
        rdchk(8'h00, 16'hA5C3);
        rdchk(8'hFF, 16'h5A3C);
    endtask

    task automatic t_mask();
        i_usr.wr(8'h10, 16'hFFFF, 16'h0000);
        i_usr.wr(8'h10, 16'h0000, 16'h00FF);
        rdchk(8'h10, 16'h00FF);
        i_usr.wr(8'h10, 16'hF0F0, 16'hFF00);
        rdchk(8'h10, 16'h00F0);
    endtask

    task automatic t_conc();
        i_usr.wr(8'h20, 16'h1234, 16'h0000);
        fork
            i_usr.wr(8'h20, 16'hBEEF, 16'h0000);
            rdchk(8'h20, 16'h1234);
        join
        rdchk(8'h20, 16'hBEEF);
    endtask

    task automatic t_narrow();
        i_usr.wr(8'h30, 16'h0000, 16'h0000);
        i_usr.wr(8'h30, 16'h0003, 16'h0002);
        rdchk(8'h30, 16'h0001);
        rdchk_nar(8'h30, 2'h3);
    endtask

    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        chk(fetch_data, 16'h0000);
        chk({14'h0000, fetch_data_nar}, 16'h0000);
        t_plain();
        t_mask();
        t_conc();
        t_narrow();
        report_and_stop();
    end
endmodule
